// File: core/clock_divider_control_pkg.sv
package clock_divider_control_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  CTRL_OFFSET    = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET  = 4'h4;
  // ----------------------------------------------------------------
  // control field layout
  // ----------------------------------------------------------------
  localparam int          PRE_LSB        = 0;
  localparam int          PRE_W          = 4;
  localparam int          RATIO_LSB      = 12;
  localparam int          RATIO_W        = 3;
  localparam int          EN_BIT         = 11;
  localparam int          ROI_BIT        = 15;
  // ----------------------------------------------------------------
  // status field layout
  // ----------------------------------------------------------------
  localparam int          ST_RATIO_REJ   = 0;
  localparam int          ST_EN_REJ      = 1;
  localparam int          ST_PRE_REJ     = 2;
  localparam int          ST_ROI_CLR     = 3;
  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [3:0]  PRE_RESET      = 4'h1;
  localparam logic [3:0]  PRE_MIN        = 4'h1;
  localparam logic [3:0]  PRE_MAX        = 4'h8;
  localparam logic [2:0]  RATIO_RESET    = 3'h0;
  localparam logic [2:0]  RATIO_ZERO     = 3'h0;
endpackage

// File: core/prescale_if.sv
`timescale 1ns/100ps
interface prescale_if;
  logic [3:0] prescale_ratio;
  logic       ref_tick;
  logic       pfd_tick;
  modport ctrl (output prescale_ratio, output ref_tick, input pfd_tick);
  modport div  (input prescale_ratio, input ref_tick, output pfd_tick);
endinterface

// File: core/ref_prescaler.sv
`timescale 1ns/100ps
module ref_prescaler (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  prescale_if.div   pre
);
  import clock_divider_control_pkg::*;

  // ----------------------------------------------------------------
  // divide reference ticks by the prescale ratio
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       tick_q;
  logic       tick_d;

  // ratio may change mid-count; a count already past the new end wraps
  // on the next reference tick, which is the short glitch the loop is expected to absorb
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (pre.ref_tick) begin
      if (cnt_q >= pre.prescale_ratio - 4'h1) begin // [R1] [R6]
        cnt_d  = 4'h0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cnt_q  <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign pre.pfd_tick = tick_q;
endmodule

// File: core/pll_prescaler_reduced_cpu_clock_ratio_control.sv
// Notes on behaviour
// R1 - prescaler divides reference by 1 to 8
// R2 - prescaler resets to divide by one
// R3 - ratio writes ignored while reduced_cpu_clock_ratio enabled
// R4 - enable ignored while ratio is zero
// R5 - interrupt clears enable when recovery set
// R6 - prescaler changes accepted while pll runs
`timescale 1ns/100ps
module pll_prescaler_reduced_cpu_clock_ratio_control (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rstn_i,
  input  wire logic [clock_divider_control_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      irq_i,
  input  wire logic                      ref_tick_i,
  output logic                           pfd_tick_o,
  output logic      [3:0]                prescale_ratio_o,
  output logic      [2:0]                reduced_cpu_clock_ratio_o,
  output logic                           reduced_cpu_clock_enable_o,
  output logic                           recover_on_interrupt_o
);
  import clock_divider_control_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // ports and the prescaler counter are fixed at these widths, and the
  // control fields must not overlap inside the 16-bit register
  if (PRE_W != 4 || RATIO_W != 3) begin
    $error("control field widths do not match the ports");
  end
  if (PRE_MIN == 4'h0 || PRE_MIN > PRE_MAX) begin
    $error("prescaler range would allow divide by zero");
  end
  if (PRE_RESET < PRE_MIN || PRE_RESET > PRE_MAX) begin
    $error("prescaler reset code outside legal range");
  end
  if (PRE_LSB + PRE_W > EN_BIT || EN_BIT >= RATIO_LSB) begin
    $error("enable bit overlaps a neighbouring field");
  end
  if (RATIO_LSB + RATIO_W > ROI_BIT || ROI_BIT > 15) begin
    $error("ratio or recovery bit outside the register");
  end
  if (CTRL_OFFSET == STATUS_OFFSET) begin
    $error("control and status share one offset");
  end
  if (ST_ROI_CLR > 3) begin
    $error("status bits do not fit the 4-bit status word");
  end
  if (ADDR_W < 3) begin
    $error("address too narrow to reach the status offset");
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  logic        ack_q;
  logic        ack_d;
  logic        req;
  logic        acc;
  logic        hit_ctrl;
  logic        hit_stat;

  assign req      = avs_read | avs_write;
  assign acc      = req & ack_q;
  assign hit_ctrl = (avs_address == CTRL_OFFSET);
  assign hit_stat = (avs_address == STATUS_OFFSET);
  assign avs_waitrequest = req & ~ack_q;

  // one wait cycle per access gives time to register read data
  always_comb begin
    ack_d = req & ~ack_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic [2:0] ratio_q;
  logic [2:0] ratio_d;
  logic       en_q;
  logic       en_d;
  logic       roi_q;
  logic       roi_d;
  logic [3:0] st_q;
  logic [3:0] st_d;
  logic       wr_ctrl;
  logic       wr_lo;
  logic       wr_hi;
  logic [3:0] new_pre;
  logic [2:0] new_ratio;
  logic       irq_recover;

  assign wr_ctrl     = acc & avs_write & hit_ctrl;
  assign wr_lo       = wr_ctrl & avs_byteenable[0];
  assign wr_hi       = wr_ctrl & avs_byteenable[1];
  assign new_pre     = avs_writedata[PRE_LSB +: PRE_W];
  assign new_ratio   = avs_writedata[RATIO_LSB +: RATIO_W];
  assign irq_recover = roi_q & irq_i & en_q;

  // status bits are sticky; an event in the clearing write wins
  always_comb begin
    pre_d   = pre_q;
    ratio_d = ratio_q;
    en_d    = en_q;
    roi_d   = roi_q;
    st_d    = st_q;
    if (acc && avs_write && hit_stat && avs_byteenable[0]) begin
      st_d = st_q & ~avs_writedata[3:0];
    end
    // reserved codes leave the divider on its last legal setting
    if (wr_lo) begin
      if (new_pre >= PRE_MIN && new_pre <= PRE_MAX) begin
        pre_d = new_pre; // [R1] [R6]
      end else begin
        st_d[ST_PRE_REJ] = 1'b1;
      end
    end
    if (wr_hi) begin
      roi_d = avs_writedata[ROI_BIT];
      if (!en_q) begin
        ratio_d = new_ratio; // [R3]
      end else if (new_ratio != ratio_q) begin
        st_d[ST_RATIO_REJ] = 1'b1; // [R3]
      end
      // judged against the ratio as it stands after this write
      if (avs_writedata[EN_BIT] && ratio_d == RATIO_ZERO) begin
        en_d = 1'b0; // [R4]
        st_d[ST_EN_REJ] = 1'b1; // [R4]
      end else begin
        en_d = avs_writedata[EN_BIT];
      end
    end
    // hardware recovery overrides a software set in the same cycle
    if (irq_recover) begin
      en_d = 1'b0; // [R5]
      st_d[ST_ROI_CLR] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pre_q   <= PRE_RESET; // [R2]
      ratio_q <= RATIO_RESET;
      en_q    <= 1'b0;
      roi_q   <= 1'b0;
      st_q    <= 4'h0;
    end else begin
      pre_q   <= pre_d;
      ratio_q <= ratio_d;
      en_q    <= en_d;
      roi_q   <= roi_d;
      st_q    <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // captured during the wait cycle; unmapped reads return zero
  always_comb begin
    rdata_d = rdata_q;
    if (avs_read && !ack_q) begin
      rdata_d = 32'h0;
      if (hit_ctrl) begin
        rdata_d[PRE_LSB +: PRE_W]     = pre_q;
        rdata_d[RATIO_LSB +: RATIO_W] = ratio_q;
        rdata_d[EN_BIT]               = en_q;
        rdata_d[ROI_BIT]              = roi_q;
      end else if (hit_stat) begin
        rdata_d[3:0] = st_q;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // reference prescaler
  // ----------------------------------------------------------------
  prescale_if pre_bus ();

  assign pre_bus.prescale_ratio = pre_q;
  assign pre_bus.ref_tick       = ref_tick_i;

  ref_prescaler ref_prescaler_inst (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .pre       (pre_bus.div)
  );

  assign pfd_tick_o                 = pre_bus.pfd_tick;
  assign prescale_ratio_o           = pre_q;
  assign reduced_cpu_clock_ratio_o  = ratio_q;
  assign reduced_cpu_clock_enable_o = en_q;
  assign recover_on_interrupt_o     = roi_q;
endmodule

// File: tb/pll_prescaler_reduced_cpu_clock_ratio_control_asserts.sv
`timescale 1ns/100ps
module pll_prescaler_reduced_cpu_clock_ratio_control_asserts
  import clock_divider_control_pkg::*;
(
  input wire logic                           sys_clk_i,
  input wire logic                           rstn_i,
  input wire logic [clock_divider_control_pkg::ADDR_W-1:0] avs_address,
  input wire logic                           avs_write,
  input wire logic [31:0]                    avs_writedata,
  input wire logic [3:0]                     avs_byteenable,
  input wire logic                           avs_waitrequest,
  input wire logic                           irq_i,
  input wire logic                           ref_tick_i,
  input wire logic                           pfd_tick_o,
  input wire logic [3:0]                     prescale_ratio_o,
  input wire logic [2:0]                     reduced_cpu_clock_ratio_o,
  input wire logic                           reduced_cpu_clock_enable_o,
  input wire logic                           recover_on_interrupt_o
);
  // ---------------------------------------------
  // control register relations
  // ---------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_pre_legal:
    assert property (prescale_ratio_o inside {[PRE_MIN:PRE_MAX]})
    else $error("prescaler left legal range");
  a_pfd_div1:
    assert property (prescale_ratio_o == 4'h1 && ref_tick_i |=> pfd_tick_o)
    else $error("divide by one lost a tick");
  a_pre_reset:
    assert property ($rose(rstn_i) |-> prescale_ratio_o == PRE_RESET)
    else $error("prescaler not at reset value");
  a_ratio_lock:
    assert property (reduced_cpu_clock_enable_o
      |=> $stable(reduced_cpu_clock_ratio_o))
    else $error("ratio changed while enabled");
  a_en_nonzero:
    assert property (reduced_cpu_clock_enable_o
      |-> reduced_cpu_clock_ratio_o != RATIO_ZERO)
    else $error("enabled with zero ratio");
  a_irq_clear:
    assert property (recover_on_interrupt_o && irq_i &&
      reduced_cpu_clock_enable_o |=> !reduced_cpu_clock_enable_o)
    else $error("interrupt did not clear enable");
  a_pre_update:
    assert property (avs_write && !avs_waitrequest &&
      avs_address == CTRL_OFFSET && avs_byteenable[0] &&
      avs_writedata[3:0] inside {[PRE_MIN:PRE_MAX]}
      |=> prescale_ratio_o == $past(avs_writedata[3:0]))
    else $error("prescaler write not taken");
endmodule
bind pll_prescaler_reduced_cpu_clock_ratio_control pll_prescaler_reduced_cpu_clock_ratio_control_asserts
  pll_prescaler_reduced_cpu_clock_ratio_control_asserts_inst (
    .sys_clk_i                  (sys_clk_i),
    .rstn_i                     (rstn_i),
    .avs_address                (avs_address),
    .avs_write                  (avs_write),
    .avs_writedata              (avs_writedata),
    .avs_byteenable             (avs_byteenable),
    .avs_waitrequest            (avs_waitrequest),
    .irq_i                      (irq_i),
    .ref_tick_i                 (ref_tick_i),
    .pfd_tick_o                 (pfd_tick_o),
    .prescale_ratio_o           (prescale_ratio_o),
    .reduced_cpu_clock_ratio_o  (reduced_cpu_clock_ratio_o),
    .reduced_cpu_clock_enable_o (reduced_cpu_clock_enable_o),
    .recover_on_interrupt_o     (recover_on_interrupt_o)
  );

// File: tb/pll_prescaler_reduced_cpu_clock_ratio_control_test.sv
`timescale 1ns/100ps
module pll_prescaler_reduced_cpu_clock_ratio_control_test;
  import clock_divider_control_pkg::*;
  // ---------------------------------------------
  // stimulus and register checks
  // ---------------------------------------------
  logic        sys_clk_i, rstn_i, avs_read, avs_write, irq_i;
  logic        ref_tick_i, avs_waitrequest, pfd_tick_o;
  logic [3:0]  avs_address, avs_byteenable, prescale_ratio_o, cur;
  logic [31:0] avs_writedata, avs_readdata;
  logic [2:0]  reduced_cpu_clock_ratio_o;
  logic        reduced_cpu_clock_enable_o, recover_on_interrupt_o;
  logic [15:0] rv;
  int          fails = 0, cmp_count = 0, pulses = 0, p0;
  pll_prescaler_reduced_cpu_clock_ratio_control pll_prescaler_reduced_cpu_clock_ratio_control_inst (
    .sys_clk_i                  (sys_clk_i),
    .rstn_i                     (rstn_i),
    .avs_address                (avs_address),
    .avs_read                   (avs_read),
    .avs_write                  (avs_write),
    .avs_writedata              (avs_writedata),
    .avs_byteenable             (avs_byteenable),
    .avs_readdata               (avs_readdata),
    .avs_waitrequest            (avs_waitrequest),
    .irq_i                      (irq_i),
    .ref_tick_i                 (ref_tick_i),
    .pfd_tick_o                 (pfd_tick_o),
    .prescale_ratio_o           (prescale_ratio_o),
    .reduced_cpu_clock_ratio_o  (reduced_cpu_clock_ratio_o),
    .reduced_cpu_clock_enable_o (reduced_cpu_clock_enable_o),
    .recover_on_interrupt_o     (recover_on_interrupt_o)
  );
  // clock, ticks every other cycle, pulse tally
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) ref_tick_i <= rstn_i & ~ref_tick_i;
  always @(posedge sys_clk_i) if (pfd_tick_o === 1'b1) pulses <= pulses + 1;
  task summarize;
    $display("compares %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  // control pins packed in register layout, checked against a constant
  task pins(input string n, input logic [15:0] e);
    chk(n, e, {recover_on_interrupt_o, reduced_cpu_clock_ratio_o,
      reduced_cpu_clock_enable_o, 7'h00, prescale_ratio_o});
  endtask
  // request held until waitrequest seen low at an edge
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[15:0];
    avs_read <= 1'b0;
  endtask
  task irq;
    @(posedge sys_clk_i);
    irq_i <= 1'b1;
    @(posedge sys_clk_i);
    irq_i <= 1'b0;
  endtask
  // hang guard, far above the roughly 3500 cycles used
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    summarize;
  end
  initial begin
    {rstn_i, avs_read, avs_write, irq_i} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h3;
    cur = PRE_RESET;
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rd(CTRL_OFFSET, rv);
    chk("ctrl reset", 16'h0001, rv);
    // every code, written while the divider keeps running
    for (int k = 0; k < 16; k++) begin
      if (k >= 1 && k <= 8) cur = k[3:0];
      wr(CTRL_OFFSET, k[15:0]);
      rd(CTRL_OFFSET, rv);
      chk("prescaler", {12'h000, cur}, rv);
      repeat (20) @(posedge sys_clk_i);
      p0 = pulses;
      repeat (32 * cur) @(posedge sys_clk_i);
      chk("pfd pulses", 16'h0010, 16'(pulses - p0));
    end
    wr(CTRL_OFFSET, 16'h0808);
    rd(CTRL_OFFSET, rv);
    chk("enable zero", 16'h0008, rv);
    wr(CTRL_OFFSET, 16'h3008);
    wr(CTRL_OFFSET, 16'h3808);
    wr(CTRL_OFFSET, 16'h5808);
    rd(CTRL_OFFSET, rv);
    chk("ratio lock", 16'h3808, rv);
    irq;
    rd(CTRL_OFFSET, rv);
    chk("irq no roi", 16'h3808, rv);
    wr(CTRL_OFFSET, 16'hb808);
    irq;
    rd(CTRL_OFFSET, rv);
    chk("irq roi", 16'hb008, rv);
    pins("pins irq roi", 16'hb008);
    wr(CTRL_OFFSET, 16'hd808);
    rd(CTRL_OFFSET, rv);
    chk("ratio free", 16'hd808, rv);
    pins("pins ratio free", 16'hd808);
    // single lanes: low lane moves only the prescaler, high lane the rest
    avs_byteenable <= 4'h1;
    wr(CTRL_OFFSET, 16'h0003);
    rd(CTRL_OFFSET, rv);
    chk("lane low", 16'hd803, rv);
    pins("pins lane low", 16'hd803);
    avs_byteenable <= 4'h2;
    wr(CTRL_OFFSET, 16'h5005);
    rd(CTRL_OFFSET, rv);
    chk("lane high", 16'h5003, rv);
    pins("pins lane high", 16'h5003);
    avs_byteenable <= 4'h3;
    rd(STATUS_OFFSET, rv);
    chk("status", 16'h000f, rv);
    wr(STATUS_OFFSET, 16'h000f);
    rd(STATUS_OFFSET, rv);
    chk("status clr", 16'h0000, rv);
    rd(4'h8, rv);
    chk("unmapped", 16'h0000, rv);
    // second reset in mid-run must restore divide by one
    @(posedge sys_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rd(CTRL_OFFSET, rv);
    chk("ctrl rerst", 16'h0001, rv);
    pins("pins rerst", 16'h0001);
    summarize;
  end
endmodule
